// *** scdf_top.sv ***
// Secondary-bus command decoder and upstream forwarding decision of a three-port bridge.
`timescale 1ns/1ps
`include "scdf_defines.svh"
// One decision per secondary address
// phase, except the low half of a dual
// cycle: claim or not, and what to
// issue upstream.
// The header sets sit behind a separate
// configuration port.
// One register stage costs a cycle of
// latency but keeps the wide compares
// away from the pins.
// All pins are synchronous to CLK.
module scdf_top import scdf_pkg::*; #(
  parameter logic [15:0] VENDOR_ID = 16'h0001, // Arbitrary value.
  parameter logic [15:0] DEVICE_ID = 16'h0002 // Arbitrary value.
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic S_ADDR_VLD,
  input wire logic S_PORT,
  input wire logic [3:0] S_CMD,
  input wire logic [31:0] S_AD,
  input wire logic CFG_WR,
  input wire logic CFG_RD,
  input wire logic [2:0] CFG_FUNC,
  input wire logic [3:0] CFG_IDX,
  input wire logic [3:0] CFG_BE,
  input wire logic [31:0] CFG_WDATA,
  output logic [31:0] CFG_RDATA,
  output logic CFG_RVLD,
  output logic DEC_VLD,
  output logic DEC_CLAIM,
  output logic [2:0] DEC_KIND,
  output logic [3:0] DEC_CMD,
  output logic [63:0] DEC_ADDR,
  output logic DEC_DAC,
  output logic DEC_PORT
);
  scdf_top_t s_r; // Registered decoder state.
  scdf_top_t s_nxt; // Next decoder state.

  // One interface per header set; set one faces secondary bus one.
  // Set two faces secondary bus two.
  // The sets differ only in which
  // primary fields software may write.
  scdf_hdr_if hif1();
  scdf_hdr_if hif2();

  // Function number selects the header set.
  // Function zero is set one, one is set two.
  logic sel1; // Access aimed at set one.
  logic sel2; // Access aimed at set two.
  assign sel1 = (CFG_FUNC == 3'h0); // RL7
  assign sel2 = (CFG_FUNC == 3'h1); // RL7
  // Higher function numbers reach no set.

  // Configuration port fan-out to both sets; only the selected one writes.
  // Index and data reach both sets; a set
  // without the strobe ignores them.
  assign hif1.wr = CFG_WR && sel1;
  assign hif1.idx = CFG_IDX;
  assign hif1.be = CFG_BE;
  assign hif1.wdata = CFG_WDATA;

  assign hif2.wr = CFG_WR && sel2;
  assign hif2.idx = CFG_IDX;
  assign hif2.be = CFG_BE;
  assign hif2.wdata = CFG_WDATA;

  // First header set, which also holds the primary-interface settings.
  // Its bus word holds the primary bus.
  scdf_hdr #(
    .IS_FIRST(1'b1),
    .VENDOR_ID(VENDOR_ID),
    .DEVICE_ID(DEVICE_ID)
  ) u_hdr1 (
    .clk(CLK),
    .rst(SYS_RST),
    .hif(hif1)
  );

  // Second header set, for secondary bus two.
  // Its primary fields always read zero.
  scdf_hdr #(
    .IS_FIRST(1'b0),
    .VENDOR_ID(VENDOR_ID),
    .DEVICE_ID(DEVICE_ID)
  ) u_hdr2 (
    .clk(CLK),
    .rst(SYS_RST),
    .hif(hif2)
  );

  // Bus numbers used by the decision.
  // All follow the requesting port except
  // the primary bus number.
  logic [7:0] pri_bus; // Primary bus number, kept in set one only.
  logic [7:0] sec_bus; // Secondary bus number of the requesting port.
  logic [7:0] sub_bus; // Subordinate bus number of the requesting port.
  logic [31:0] mem_dw; // Memory window of the requesting port.
  logic [31:0] pf_dw; // Prefetchable window of the requesting port.
  logic [31:0] pfu_base; // Prefetchable base, upper half.
  logic [31:0] pfu_lim; // Prefetchable limit, upper half.
  logic port_now; // Port of the address phase being decided.

  // The port of a dual address cycle is the one that opened it.
  // The high half may show other port
  // lines, so the first half's port counts.
  assign port_now = (s_r.st == SCDF_DAC_HI) ? s_r.dac_port : S_PORT;

  // Pick the header set that serves the requesting secondary bus.
  // Set two keeps zero as its primary bus
  // and is never asked for it.
  always_comb begin
    pri_bus = hif1.bus_dw[7:0]; // RL10

    if (port_now) begin
      sec_bus = hif2.bus_dw[15:8]; // RL9
      sub_bus = hif2.bus_dw[23:16];
      mem_dw = hif2.mem_dw;
      pf_dw = hif2.pf_dw;
      pfu_base = hif2.pfu_base;
      pfu_lim = hif2.pfu_lim;
    end else begin
      sec_bus = hif1.bus_dw[15:8]; // RL9
      sub_bus = hif1.bus_dw[23:16];
      mem_dw = hif1.mem_dw;
      pf_dw = hif1.pf_dw;
      pfu_base = hif1.pfu_base;
      pfu_lim = hif1.pfu_lim;
    end
  end

  // Memory window test; an address inside either window belongs downstream.
  // The plain window covers the low 4 GB;
  // the prefetchable one spans 64 bits.
  // Both compare at 1 MB granularity.
  // A base above its limit matches nothing,
  // which is how software turns a window off.
  function automatic logic in_window(input logic [63:0] a, input logic [31:0] mw, input logic [31:0] pw,
                                     input logic [31:0] pub, input logic [31:0] pul);
    logic in_mem;
    logic in_pf;
    logic [43:0] a44;

    in_mem = (a[63:32] == 32'h00000000) && (a[31:20] >= mw[15:4]) && (a[31:20] <= mw[31:20]);
    a44 = {a[63:32], a[31:20]};
    in_pf = (a44 >= {pub, pw[15:4]}) && (a44 <= {pul, pw[31:20]});
    return in_mem || in_pf;
  endfunction

  // Type 1 configuration address fields of the current phase.
  // Bus in 23:16, device in 15:11,
  // function in 10:8, type in 1:0.
  logic is_type1; // Address bits mark a Type 1 access.
  logic is_spc_req; // Type 1 write that asks for a special cycle.
  logic [7:0] tgt_bus; // Target bus number of a Type 1 access.
  logic in_range; // Target bus lies between secondary and subordinate.
  logic [63:0] addr_now; // Full address of the phase being decided.
  logic dac_now; // Phase is the second half of a dual address cycle.

  // Address fields; a dual cycle joins its two halves into 64 bits.
  // The Type 1 terms also form on a high
  // half, but the decision ignores them.
  always_comb begin
    dac_now = (s_r.st == SCDF_DAC_HI);
    addr_now = dac_now ? {S_AD, s_r.dac_lo} : {32'h00000000, S_AD}; // RL13
    is_type1 = (S_AD[1:0] == `SCDF_CFG_TYPE1);
    is_spc_req = is_type1 && (S_AD[15:11] == `SCDF_SPC_DEV) && (S_AD[10:8] == `SCDF_SPC_FUNC); // RL3
    tgt_bus = S_AD[23:16];

    // Both range ends are inclusive.
    in_range = (tgt_bus >= sec_bus) && (tgt_bus <= sub_bus);
  end

  // Decision for one address phase; the outcome is held until the next phase.
  // Pulses fall every cycle; other fields
  // hold until a new phase or read.
  // Reset clears everything at once.
  // Only this process writes s_nxt.
  always_comb begin
    s_nxt = s_r;
    s_nxt.dec_vld = 1'b0;
    s_nxt.cfg_rvld = 1'b0;

    if (SYS_RST) begin
      s_nxt = '0;
      s_nxt.st = SCDF_IDLE;
    end else begin
      // Configuration read of the selected header set.
      // Data is taken before a write of the
      // same cycle lands: the old value.
      if (CFG_RD) begin
        s_nxt.cfg_rvld = 1'b1;
        if (sel1) begin
          s_nxt.cfg_rdata = hif1.rdata; // RL7
        end else if (sel2) begin
          s_nxt.cfg_rdata = hif2.rdata; // RL7
        end else begin
          // No header set behind other function numbers; read as all ones.
          s_nxt.cfg_rdata = `SCDF_NO_FUNC;
        end
      end

      // The low half of a dual cycle only
      // arms the state; the high half decides.
      if (S_ADDR_VLD) begin
        unique case (s_r.st)
          SCDF_IDLE: begin
            if (S_CMD == `SCDF_CMD_DAC) begin
              // Hold the low half; the real command follows in the next phase.
              // The port is kept for the high half.
              s_nxt.st = SCDF_DAC_HI; // RL13
              s_nxt.dac_lo = S_AD;
              s_nxt.dac_port = S_PORT;
            end
          end
          SCDF_DAC_HI: begin
            // The high half always ends the cycle.
            s_nxt.st = SCDF_IDLE;
          end
        endcase
        // A decision is reported for every phase except the first DAC half.
        // Fields start from the ignore outcome.
        if (!(s_r.st == SCDF_IDLE && S_CMD == `SCDF_CMD_DAC)) begin
          s_nxt.dec_vld = 1'b1;
          s_nxt.dec_claim = 1'b0;
          s_nxt.dec_kind = `SCDF_KIND_NONE;
          s_nxt.dec_cmd = S_CMD;
          s_nxt.dec_addr = addr_now;
          s_nxt.dec_dac = dac_now;
          s_nxt.dec_port = port_now;

          // Unlisted codes take the default.
          unique case (S_CMD)
            `SCDF_CMD_MEM_RD, `SCDF_CMD_MEM_WR, `SCDF_CMD_MEM_RDM, `SCDF_CMD_MEM_RDL, `SCDF_CMD_MEM_WI: begin
              // All memory variants share one window test.
              // Outside both windows of its port,
              // an access is sent upstream.
              // Inside, it stays below the bridge.
              if (!in_window(addr_now, mem_dw, pf_dw, pfu_base, pfu_lim)) begin // RL12
                s_nxt.dec_claim = 1'b1;
                s_nxt.dec_kind = `SCDF_KIND_MEM; // RL12
              end
            end
            `SCDF_CMD_CFG_WR: begin
              // Configuration writes cannot ride a dual cycle; such a phase is ignored.
              // The primary test comes first: the
              // primary bus may be in range too.
              if (dac_now || !is_type1) begin
                s_nxt.dec_claim = 1'b0; // RL1
              end else if (!is_spc_req) begin
                s_nxt.dec_claim = 1'b0; // RL2
              end else if (tgt_bus == pri_bus) begin
                s_nxt.dec_claim = 1'b1; // RL4
                s_nxt.dec_kind = `SCDF_KIND_SPECIAL;
                // Upstream it becomes a special cycle.
                s_nxt.dec_cmd = `SCDF_CMD_SPECIAL; // RL4
              end else if (!in_range) begin
                // Command and address pass unchanged.
                s_nxt.dec_claim = 1'b1; // RL5
                s_nxt.dec_kind = `SCDF_KIND_TYPE1; // RL5
              end else begin
                s_nxt.dec_claim = 1'b0; // RL6
              end
            end
            `SCDF_CMD_SPECIAL: begin
              // Special cycles stay on the bus that carries them.
              // No other bus wants a local broadcast.
              s_nxt.dec_claim = 1'b0; // RL11
            end
            default: begin
              // Configuration reads and commands outside this block's scope are ignored.
              // I/O and reserved codes land here.
              s_nxt.dec_claim = 1'b0;
            end
          endcase
        end
      end
    end
  end

  // State register; every output is a bit of it.
  // Reset lives in the next-state logic,
  // so this stays a plain register.
  always_ff @(posedge CLK) begin
    s_r <= s_nxt;
  end

  // Outputs straight from the state register.
  // No logic sits between flop and pin.
  assign CFG_RDATA = s_r.cfg_rdata;
  assign CFG_RVLD = s_r.cfg_rvld;

  // Decision outputs.
  assign DEC_VLD = s_r.dec_vld;
  assign DEC_CLAIM = s_r.dec_claim;
  assign DEC_KIND = s_r.dec_kind;
  assign DEC_CMD = s_r.dec_cmd;
  assign DEC_ADDR = s_r.dec_addr;
  assign DEC_DAC = s_r.dec_dac;
  assign DEC_PORT = s_r.dec_port;
endmodule

// *** scdf_defines.svh ***
// Constants for the secondary-bus command decoder and its configuration header sets.
// What this block does
// (RL1) Type 0 configuration write: never claim, never forward.
// (RL2) Type 1 write, not special request: leave unclaimed.
// (RL3) Special request means device 1Fh, function 7h.
// (RL4) Request to primary bus: claim, issue Special Cycle.
// (RL5) Bus outside primary and range: claim, forward Type 1.
// (RL6) Bus inside secondary-subordinate range: ignore request.
// (RL7) Two header sets, selected by function number.
// (RL8) Each set offers a 64-byte standard header.
// (RL9) Set one serves bus one, set two bus two.
// (RL10) Primary interface settings live only in set one.
// (RL11) Special Cycle command on secondary: neither claim nor forward.
// (RL12) Burst memory commands use plain memory read windows.
// (RL13) Accept dual address cycles, decode 64-bit address.
`ifndef SCDF_DEFINES_SVH
`define SCDF_DEFINES_SVH
// Bus command codes.
`define SCDF_CMD_SPECIAL 4'h1
`define SCDF_CMD_MEM_RD 4'h6
`define SCDF_CMD_MEM_WR 4'h7
`define SCDF_CMD_CFG_RD 4'ha
`define SCDF_CMD_CFG_WR 4'hb
`define SCDF_CMD_MEM_RDM 4'hc
`define SCDF_CMD_DAC 4'hd
`define SCDF_CMD_MEM_RDL 4'he
`define SCDF_CMD_MEM_WI 4'hf
// Configuration address fields of a Type 1 access.
`define SCDF_CFG_TYPE1 2'h1
`define SCDF_SPC_DEV 5'h1f
`define SCDF_SPC_FUNC 3'h7
// Header dword indices; the header is 16 dwords, 64 bytes.
`define SCDF_HDR_DWORDS 16
`define SCDF_IDX_ID 4'h0
`define SCDF_IDX_CLASS 4'h2
`define SCDF_IDX_MISC 4'h3
`define SCDF_IDX_BUS 4'h6
`define SCDF_IDX_MEM 4'h8
`define SCDF_IDX_PF 4'h9
`define SCDF_IDX_PFU_BASE 4'ha
`define SCDF_IDX_PFU_LIM 4'hb
// Writable bit masks per header dword.
`define SCDF_WM_MISC 32'h0000ffff
`define SCDF_WM_BUS 32'hffffffff
`define SCDF_WM_WIN 32'hfff0fff0
`define SCDF_WM_FULL 32'hffffffff
// Primary-interface fields that only the first set keeps.
`define SCDF_PRI_MISC 32'h0000ff00
`define SCDF_PRI_BUS 32'h000000ff
// Header type reset value and read data of absent functions.
`define SCDF_HDR_TYPE 8'h01
`define SCDF_NO_FUNC 32'hffffffff
// Decision kinds.
`define SCDF_KIND_NONE 3'h0
`define SCDF_KIND_SPECIAL 3'h1
`define SCDF_KIND_TYPE1 3'h2
`define SCDF_KIND_MEM 3'h3
`endif

// *** scdf_pkg.sv ***
// Types shared by the secondary-bus command decoder modules.
package scdf_pkg;
  // Address phase tracking; a dual address cycle takes two phases.
  typedef enum logic [0:0] {SCDF_IDLE, SCDF_DAC_HI} scdf_state_t;
  // All state of the decoder top.
  typedef struct packed {
    scdf_state_t st;
    logic [31:0] dac_lo;
    logic dac_port;
    logic dec_vld;
    logic dec_claim;
    logic [2:0] dec_kind;
    logic [3:0] dec_cmd;
    logic [63:0] dec_addr;
    logic dec_dac;
    logic dec_port;
    logic [31:0] cfg_rdata;
    logic cfg_rvld;
  } scdf_top_t;
  // All state of one configuration header set.
  typedef struct packed {
    logic [15:0][31:0] dw;
  } scdf_hdr_t;
endpackage

// *** scdf_hdr_if.sv ***
// Interface between the decoder top and one configuration header set.
`timescale 1ns/1ps
interface scdf_hdr_if;
  logic wr; // Write strobe for this set.
  logic [3:0] idx; // Dword index within the header.
  logic [3:0] be; // Byte enables, active high.
  logic [31:0] wdata; // Write data.
  logic [31:0] rdata; // Read data of the indexed dword.
  logic [31:0] bus_dw; // Bus number dword.
  logic [31:0] mem_dw; // Memory window dword.
  logic [31:0] pf_dw; // Prefetchable window dword.
  logic [31:0] pfu_base; // Upper 32 bits of prefetchable base.
  logic [31:0] pfu_lim; // Upper 32 bits of prefetchable limit.
  modport owner(input wr, idx, be, wdata, output rdata, bus_dw, mem_dw, pf_dw, pfu_base, pfu_lim);
  modport user(output wr, idx, be, wdata, input rdata, bus_dw, mem_dw, pf_dw, pfu_base, pfu_lim);
endinterface

// *** scdf_hdr.sv ***
// One 64-byte configuration header set of the bridge.
`timescale 1ns/1ps
`include "scdf_defines.svh"
module scdf_hdr import scdf_pkg::*; #(
  parameter bit IS_FIRST = 1'b1,
  parameter logic [15:0] VENDOR_ID = 16'h0001, // Arbitrary value.
  parameter logic [15:0] DEVICE_ID = 16'h0002, // Arbitrary value.
  parameter logic [31:0] CLASS_REV = 32'h06040000
) (
  input wire logic clk,
  input wire logic rst,
  scdf_hdr_if.owner hif
);
  scdf_hdr_t s_r; // Registered header state.
  scdf_hdr_t s_nxt; // Next header state.
  logic [31:0] wm; // Writable mask of the indexed dword.

  // Writable mask; the second set drops the primary-interface fields.
  always_comb begin
    unique case (hif.idx)
      `SCDF_IDX_MISC: wm = IS_FIRST ? `SCDF_WM_MISC : (`SCDF_WM_MISC & ~`SCDF_PRI_MISC); // RL10
      `SCDF_IDX_BUS: wm = IS_FIRST ? `SCDF_WM_BUS : (`SCDF_WM_BUS & ~`SCDF_PRI_BUS); // RL10
      `SCDF_IDX_MEM, `SCDF_IDX_PF: wm = `SCDF_WM_WIN;
      `SCDF_IDX_PFU_BASE, `SCDF_IDX_PFU_LIM: wm = `SCDF_WM_FULL;
      default: wm = 32'h00000000;
    endcase
  end

  // Byte-lane write under mask; read-only words keep their reset contents.
  always_comb begin
    s_nxt = s_r;
    if (rst) begin
      s_nxt.dw = '0;
      s_nxt.dw[`SCDF_IDX_ID] = {DEVICE_ID, VENDOR_ID};
      s_nxt.dw[`SCDF_IDX_CLASS] = CLASS_REV;
      s_nxt.dw[`SCDF_IDX_MISC][23:16] = `SCDF_HDR_TYPE;
    end else if (hif.wr) begin
      for (int b = 0; b < 4; b++) begin
        if (hif.be[b]) begin
          s_nxt.dw[hif.idx][b*8 +: 8] = (s_r.dw[hif.idx][b*8 +: 8] & ~wm[b*8 +: 8]) |
                                         (hif.wdata[b*8 +: 8] & wm[b*8 +: 8]); // RL8
        end
      end
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    s_r <= s_nxt;
  end

  // Fields exported to the decoder and the read path.
  assign hif.rdata = s_r.dw[hif.idx];
  assign hif.bus_dw = s_r.dw[`SCDF_IDX_BUS];
  assign hif.mem_dw = s_r.dw[`SCDF_IDX_MEM];
  assign hif.pf_dw = s_r.dw[`SCDF_IDX_PF];
  assign hif.pfu_base = s_r.dw[`SCDF_IDX_PFU_BASE];
  assign hif.pfu_lim = s_r.dw[`SCDF_IDX_PFU_LIM];
endmodule

// *** scdf_props.sv ***
// Port-level assertions and covers for the secondary-bus command decoder.
`timescale 1ns/1ps
module scdf_props (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic S_ADDR_VLD,
  input wire logic S_PORT,
  input wire logic [3:0] S_CMD,
  input wire logic [31:0] S_AD,
  input wire logic CFG_WR,
  input wire logic CFG_RD,
  input wire logic [2:0] CFG_FUNC,
  input wire logic [3:0] CFG_IDX,
  input wire logic [3:0] CFG_BE,
  input wire logic [31:0] CFG_WDATA,
  input wire logic [31:0] CFG_RDATA,
  input wire logic CFG_RVLD,
  input wire logic DEC_VLD,
  input wire logic DEC_CLAIM,
  input wire logic [2:0] DEC_KIND,
  input wire logic [3:0] DEC_CMD,
  input wire logic [63:0] DEC_ADDR,
  input wire logic DEC_DAC,
  input wire logic DEC_PORT
);
  logic dac_r; // High while a dual address cycle waits for its high half.
  logic [31:0] lo_r; // Low half of the pending dual address cycle.
  logic ph; // A phase that starts a new decision.
  logic spc; // A Type 1 write that asks for a special cycle.
  assign ph = S_ADDR_VLD && !dac_r;
  assign spc = ph && S_CMD == 4'hb && S_AD[1:0] == 2'h1 && S_AD[15:8] == 8'hff;
  // Track phase pairing so the high half is never mistaken for a new command.
  always_ff @(posedge CLK) begin
    if (SYS_RST) dac_r <= 1'b0;
    else if (S_ADDR_VLD) dac_r <= !dac_r && S_CMD == 4'hd;
    if (ph) lo_r <= S_AD;
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  property p_vld; ph && S_CMD != 4'hd |=> DEC_VLD && !DEC_DAC && DEC_PORT == $past(S_PORT); endproperty
  a_vld: assert property (p_vld) else $error("decision missing after phase");
  property p_dac1; ph && S_CMD == 4'hd |=> !DEC_VLD; endproperty
  a_dac1: assert property (p_dac1) else $error("decision after first dual phase");
  property p_dac2; S_ADDR_VLD && dac_r |=> DEC_VLD && DEC_DAC && DEC_ADDR == {$past(S_AD), lo_r}; endproperty
  a_dac2: assert property (p_dac2) else $error("dual address not joined");
  property p_t0; ph && S_CMD == 4'hb && S_AD[1:0] == 2'h0 |=> !DEC_CLAIM; endproperty
  a_t0: assert property (p_t0) else $error("type 0 write claimed");
  property p_t1; ph && S_CMD == 4'hb && S_AD[1:0] == 2'h1 && !spc |=> !DEC_CLAIM; endproperty
  a_t1: assert property (p_t1) else $error("plain type 1 write claimed");
  property p_low; ph && S_CMD inside {4'h1, 4'ha} |=> !DEC_CLAIM; endproperty
  a_low: assert property (p_low) else $error("special or read claimed");
  property p_spc; DEC_VLD && DEC_KIND == 3'h1 |-> DEC_CLAIM && DEC_CMD == 4'h1 && $past(spc); endproperty
  a_spc: assert property (p_spc) else $error("bad special cycle issue");
  property p_fwd; DEC_VLD && DEC_KIND == 3'h2 |-> DEC_CLAIM && DEC_CMD == 4'hb && $past(spc)
    && DEC_ADDR == {32'h0, $past(S_AD)}; endproperty
  a_fwd: assert property (p_fwd) else $error("type 1 forward altered");
  property p_mem; DEC_VLD && DEC_KIND == 3'h3 |-> DEC_CLAIM && DEC_CMD == $past(S_CMD)
    && DEC_CMD inside {4'h6, 4'h7, 4'hc, 4'he, 4'hf}; endproperty
  a_mem: assert property (p_mem) else $error("bad memory forward");
  property p_rd; CFG_RD |=> CFG_RVLD; endproperty
  a_rd: assert property (p_rd) else $error("config read not answered");
  property p_nof; CFG_RD && CFG_FUNC > 3'h1 |=> CFG_RDATA == 32'hffffffff; endproperty
  a_nof: assert property (p_nof) else $error("absent function answered");
  c_spc: cover property (DEC_VLD && DEC_KIND == 3'h1);
  c_fwd: cover property (DEC_VLD && DEC_KIND == 3'h2);
  c_dac: cover property (DEC_VLD && DEC_DAC && DEC_CLAIM);
endmodule
bind scdf_top scdf_props u_props (.CLK(CLK), .SYS_RST(SYS_RST), .S_ADDR_VLD(S_ADDR_VLD), .S_PORT(S_PORT),
  .S_CMD(S_CMD), .S_AD(S_AD), .CFG_WR(CFG_WR), .CFG_RD(CFG_RD), .CFG_FUNC(CFG_FUNC), .CFG_IDX(CFG_IDX),
  .CFG_BE(CFG_BE), .CFG_WDATA(CFG_WDATA), .CFG_RDATA(CFG_RDATA), .CFG_RVLD(CFG_RVLD), .DEC_VLD(DEC_VLD),
  .DEC_CLAIM(DEC_CLAIM), .DEC_KIND(DEC_KIND), .DEC_CMD(DEC_CMD), .DEC_ADDR(DEC_ADDR), .DEC_DAC(DEC_DAC),
  .DEC_PORT(DEC_PORT));

// *** scdf_init_model.sv ***
// Secondary-bus initiator model that presents address phases to the decoder.
`timescale 1ns/1ps
module scdf_init_model (
  input wire logic clk,
  output logic vld,
  output logic port,
  output logic [3:0] cmd,
  output logic [31:0] ad
);
  // Bus is idle at time zero.
  initial begin
    vld = 1'b0;
    port = 1'b0;
    cmd = 4'h0;
    ad = 32'h0;
  end
  // One address phase for a single edge; a dual cycle is two calls, low half first.
  task automatic phase(input logic p, input logic [3:0] c, input logic [31:0] a);
    vld = 1'b1;
    port = p;
    cmd = c;
    ad = a;
    @(posedge clk);
    #2;
  endtask
  // Release the bus; the lines turn over so a stale value can never pass as valid.
  task automatic idle();
    vld = 1'b0;
    ad = ~ad;
    cmd = ~cmd;
    @(posedge clk);
    #2;
  endtask
endmodule

// *** tb_top.sv ***
// Self-checking bench for the secondary-bus command decoder.
`timescale 1ns/1ps
module tb_top;
  logic CLK, SYS_RST, S_ADDR_VLD, S_PORT, CFG_WR, CFG_RD, CFG_RVLD, DEC_VLD, DEC_CLAIM, DEC_DAC, DEC_PORT;
  logic [3:0] S_CMD, CFG_IDX, CFG_BE, DEC_CMD;
  logic [31:0] S_AD, CFG_WDATA, CFG_RDATA;
  logic [2:0] CFG_FUNC, DEC_KIND;
  logic [63:0] DEC_ADDR;
  int err_count = 0;
  int total_checks = 0;
  logic [73:0] exp_q[$]; // Expected {claim, kind, cmd, dac, port, addr} per decision.
  logic [73:0] e, s, m;
  logic [3:0] c;
  logic [31:0] lo;
  // Bus numbers and windows that the bench programs; index is the port.
  localparam logic [7:0] PRI = 8'h05;
  localparam logic [7:0] SEC [2] = '{8'h10, 8'h20};
  localparam logic [7:0] SUB [2] = '{8'h1f, 8'h2f};
  localparam logic [11:0] MB [2] = '{12'h100, 12'h300};
  localparam logic [11:0] PB [2] = '{12'h200, 12'h400};
  localparam logic [31:0] PU [2] = '{32'h0, 32'h1};
  localparam logic [7:0] BUSL [8] = '{8'h05, 8'h10, 8'h1f, 8'h20, 8'h2f, 8'h30, 8'h00, 8'hff};
  localparam logic [3:0] C2 [6] = '{4'h6, 4'h7, 4'hc, 4'he, 4'hf, 4'hb};
  scdf_top uut (.CLK(CLK), .SYS_RST(SYS_RST), .S_ADDR_VLD(S_ADDR_VLD), .S_PORT(S_PORT), .S_CMD(S_CMD),
    .S_AD(S_AD), .CFG_WR(CFG_WR), .CFG_RD(CFG_RD), .CFG_FUNC(CFG_FUNC), .CFG_IDX(CFG_IDX), .CFG_BE(CFG_BE),
    .CFG_WDATA(CFG_WDATA), .CFG_RDATA(CFG_RDATA), .CFG_RVLD(CFG_RVLD), .DEC_VLD(DEC_VLD),
    .DEC_CLAIM(DEC_CLAIM), .DEC_KIND(DEC_KIND), .DEC_CMD(DEC_CMD), .DEC_ADDR(DEC_ADDR), .DEC_DAC(DEC_DAC),
    .DEC_PORT(DEC_PORT));
  scdf_init_model ini (.clk(CLK), .vld(S_ADDR_VLD), .port(S_PORT), .cmd(S_CMD), .ad(S_AD));
  // 20 MHz clock.
  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  // Count and report one comparison.
  task automatic chk(input string n, input logic [73:0] ex, input logic [73:0] sn);
    total_checks++;
    if (sn !== ex) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, ex, sn);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Config accesses leave one idle edge so a strobe is never set twice in a time step.
  task automatic cfgw(input logic [2:0] f, input logic [3:0] i, input logic [31:0] d);
    CFG_WR = 1'b1;
    CFG_FUNC = f;
    CFG_IDX = i;
    CFG_WDATA = d;
    @(posedge CLK);
    #2;
    CFG_WR = 1'b0;
    @(posedge CLK);
    #2;
  endtask
  task automatic cfgr(input logic [2:0] f, input logic [3:0] i, input logic [31:0] ex);
    CFG_RD = 1'b1;
    CFG_FUNC = f;
    CFG_IDX = i;
    @(posedge CLK);
    #2;
    CFG_RD = 1'b0;
    chk("cfg_rvld", 74'h1, 74'(CFG_RVLD));
    chk("cfg_rdata", 74'(ex), 74'(CFG_RDATA));
    @(posedge CLK);
    #2;
  endtask
  // Reference decision; the primary test wins before the range test.
  function automatic logic [73:0] model(input logic p, input logic [3:0] cm, input logic [31:0] l,
    input logic [31:0] h, input logic d);
    logic [63:0] a;
    logic [3:0] k;
    a = d ? {h, l} : {32'h0, l};
    k = 4'h0;
    if (cm == 4'hb && !d && l[1:0] == 2'h1 && l[15:8] == 8'hff) begin
      if (l[23:16] == PRI) k = 4'h9;
      else if (l[23:16] < SEC[p] || l[23:16] > SUB[p]) k = 4'ha;
    end else if (cm inside {4'h6, 4'h7, 4'hc, 4'he, 4'hf}) begin
      if (!(a >= {32'h0, MB[p], 20'h0} && a <= {32'h0, MB[p] + 12'hff, 20'hfffff})
        && !(a >= {PU[p], PB[p], 20'h0} && a <= {PU[p], PB[p] + 12'hff, 20'hfffff})) k = 4'hb;
    end
    return {k, (k == 4'h9) ? 4'h1 : cm, d, p, a};
  endfunction
  // Queue the expectation, then present one decision's phases.
  task automatic issue(input logic p, input logic [3:0] cm, input logic [31:0] l, input logic [31:0] h);
    if (cm == 4'hd) begin
      exp_q.push_back(model(p, C2[h[3:0] % 6], l, h >> 4, 1'b1));
      ini.phase(p, cm, l);
      ini.phase(p, C2[h[3:0] % 6], h >> 4);
    end else begin
      exp_q.push_back(model(p, cm, l, 32'h0, 1'b0));
      ini.phase(p, cm, l);
    end
  endtask
  // Every decision is compared at the cycle it is flagged; unclaimed ones only by claim, kind, dac and port.
  always @(negedge CLK) begin
    if (DEC_VLD === 1'b1) begin
      if (exp_q.size() == 0) chk("dec_vld", 74'h0, 74'h1);
      else begin
        e = exp_q.pop_front();
        s = {DEC_CLAIM, DEC_KIND, DEC_CMD, DEC_DAC, DEC_PORT, DEC_ADDR};
        m = e[73] ? '1 : {4'hf, 4'h0, 2'h3, 64'h0};
        chk("decision", e & m, s & m);
      end
    end
  end
  // A hang ends the run as a failure.
  initial begin
    #2000000;
    err_count++;
    $display("[ERR] run limit expected 0 seen 1");
    test_done();
  end
  initial begin
    SYS_RST = 1'b1;
    CFG_WR = 1'b0;
    CFG_RD = 1'b0;
    CFG_FUNC = 3'h0;
    CFG_IDX = 4'h0;
    CFG_BE = 4'hf;
    CFG_WDATA = 32'h0;
    void'($urandom(62152));
    repeat (5) @(posedge CLK);
    #2;
    SYS_RST = 1'b0;
    cfgr(3'h0, 4'h0, 32'h00020001);
    cfgr(3'h1, 4'h0, 32'h00020001);
    cfgr(3'h0, 4'h3, 32'h00010000);
    cfgr(3'h0, 4'hf, 32'h0);
    cfgr(3'h2, 4'h0, 32'hffffffff);
    cfgw(3'h0, 4'h0, 32'h12345678);
    cfgr(3'h0, 4'h0, 32'h00020001);
    CFG_BE = 4'h1;
    cfgw(3'h0, 4'h3, 32'h0000abcd);
    CFG_BE = 4'hf;
    cfgr(3'h0, 4'h3, 32'h000100cd);
    CFG_BE = 4'h3;
    cfgw(3'h1, 4'h3, 32'h0000ffff);
    CFG_BE = 4'hf;
    cfgr(3'h1, 4'h3, 32'h000100ff);
    cfgw(3'h0, 4'h6, 32'h001f1005);
    cfgw(3'h1, 4'h6, 32'h002f2077);
    cfgw(3'h5, 4'h6, 32'hffffffff);
    cfgr(3'h0, 4'h6, 32'h001f1005);
    cfgr(3'h1, 4'h6, 32'h002f2000);
    cfgw(3'h0, 4'h8, 32'h1ff01000);
    cfgw(3'h0, 4'h9, 32'h2ff02000);
    cfgw(3'h1, 4'h8, 32'h3ff03000);
    cfgw(3'h1, 4'h9, 32'h4ff04000);
    cfgw(3'h1, 4'ha, 32'h1);
    cfgw(3'h1, 4'hb, 32'h1);
    issue(1'b1, 4'hb, 32'h0005ff01, 32'h0);
    issue(1'b0, 4'hd, 32'h40000000, 32'h10);
    issue(1'b1, 4'hd, 32'h41234560, 32'h12);
    for (int i = 0; i < 16; i++) issue(i[0], 4'(i), 32'h5000ff01, 32'h22);
    repeat (300) begin
      c = 4'($urandom % 16);
      lo = {4'($urandom % 6), 28'($urandom)};
      if (c == 4'hb || $urandom % 4 == 0)
        lo = {8'h0, BUSL[$urandom % 8], ($urandom % 2) ? 8'hff : 8'($urandom), 6'h0, 2'($urandom)};
      issue(1'($urandom), c, lo, 32'($urandom % 32));
      if ($urandom % 3 == 0) ini.idle();
    end
    ini.idle();
    for (int i = 0; i < 20 && exp_q.size() > 0; i++) @(posedge CLK);
    chk("drain", 74'h0, 74'(exp_q.size()));
    test_done();
  end
endmodule
